// ==== piar_map.vh ====
`ifndef PIAR_MAP_VH
`define PIAR_MAP_VH

// Register offsets on the management interface
`define PIAR_OFS_ID_HIGH 5'h02
`define PIAR_OFS_ID_LOW 5'h03
`define PIAR_OFS_ADV 5'h04
`define PIAR_OFS_PARTNER 5'h05

// Second identifier fields
`define PIAR_IDL_OUI_MSB 15
`define PIAR_IDL_OUI_LSB 10
`define PIAR_IDL_MODEL_MSB 9
`define PIAR_IDL_MODEL_LSB 4
`define PIAR_IDL_REV_MSB 3
`define PIAR_IDL_REV_LSB 0

// Advertisement and partner fields
`define PIAR_BIT_NEXT_PAGE 15
`define PIAR_BIT_ACK 14
`define PIAR_BIT_RFAULT 13
`define PIAR_BIT_PAUSE_ASYM 11
`define PIAR_BIT_PAUSE_SYM 10
`define PIAR_BIT_LP_PAUSE 10
`define PIAR_BIT_T4 9
`define PIAR_BIT_100FD 8
`define PIAR_BIT_100 7
`define PIAR_BIT_10FD 6
`define PIAR_BIT_10 5
`define PIAR_SEL_MSB 4
`define PIAR_SEL_LSB 0

// Writable and readable masks, reserved positions are zero
`define PIAR_ADV_WMASK 16'h2DFF
`define PIAR_LP_MASK 16'hE7FF

// Reset values
`define PIAR_SEL_IEEE 5'h01
`define PIAR_PAUSE_NONE 2'b00
`define PIAR_ADV_RST_FIXED 16'h0081

// Serial frame constants
`define PIAR_PREAMBLE_LEN 6'h20
`define PIAR_OP_READ 2'b10
`define PIAR_OP_WRITE 2'b01

`endif

// ==== piar_sync.v ====
`timescale 1ns/1ps
module piar_sync #(
  parameter WIDTH = 1
) (
  // Clock
  input wire i_ref_clk,
  // Asynchronous levels in, synchronised levels out
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      reg meta;
      reg stable;
      always @(posedge i_ref_clk)
      begin
        meta <= i_async[g];
        stable <= meta;
      end
      assign o_sync[g] = stable;
    end
  endgenerate

endmodule

// ==== piar_regs.v ====
// What this block does
// - First ID register holds OUI bits 3..18
// - Second ID top field holds OUI bits 19..24
// - Second ID middle field holds model code
// - Revision nibble reset follows silicon revision
// - Pause field encodes four choices, resets none
// - Both pauses advertised resolve to at most one
// - Strap pins load 100FD, 10FD, 10 at reset
// - Four writable ability bits, 100 resets one
// - Local remote fault writable, partner's read-only
// - Partner next page read-only, resets zero
// - Acknowledge reads one after code word received
// - Partner pause support in one read-only bit
// - Partner T4 ability shown read-only
// - Partner speed and duplex abilities read-only, zero
// - Negotiated result overrides manual speed and duplex
`timescale 1ns/1ps
`include "piar_map.vh"
module piar_regs #(
  parameter [15:0] OUI_HIGH_RST = 16'h1234,
  parameter [5:0] OUI_LOW_RST = 6'h2A,
  parameter [5:0] MODEL_RST = 6'h15
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_sys_rst,
  // Management serial pins
  input wire i_mdc,
  input wire i_mdio,
  output reg o_mdio,
  output reg o_mdio_oe_n,
  // Straps and silicon revision
  input wire [4:0] i_phy_addr,
  input wire [2:0] i_mode_strap,
  input wire [3:0] i_silicon_rev,
  // Negotiation engine
  input wire i_lcw_valid,
  input wire [15:0] i_lcw,
  input wire i_lcw_clear,
  input wire i_an_complete,
  // Basic control selections
  input wire i_an_enable,
  input wire i_manual_speed100,
  input wire i_manual_full_duplex,
  // Advertised word and resolved link
  output reg [15:0] o_adv_word,
  output reg o_speed100,
  output reg o_full_duplex,
  output reg o_pause_sym,
  output reg o_pause_asym
);

  localparam ST_IDLE = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_OPCODE = 3'd2;
  localparam ST_ADDR = 3'd3;
  localparam ST_TA = 3'd4;
  localparam ST_RDATA = 3'd5;
  localparam ST_WDATA = 3'd6;

  wire mdc_s;
  wire mdio_s;
  wire [4:0] phy_addr_s;
  wire [2:0] mode_s;
  wire [3:0] rev_s;

  piar_sync #(
    .WIDTH(14)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_async({i_mdc, i_mdio, i_phy_addr, i_mode_strap, i_silicon_rev}),
    .o_sync({mdc_s, mdio_s, phy_addr_s, mode_s, rev_s})
  );

  reg mdc_d;
  wire mdc_rise;
  assign mdc_rise = mdc_s & ~mdc_d;

  reg [15:0] id_high;
  reg [15:0] id_low;
  reg [15:0] partner;
  reg [2:0] state;
  reg [5:0] pre_cnt;
  reg [4:0] bit_cnt;
  reg [1:0] opcode;
  reg [9:0] addr_sh;
  reg [15:0] data_sh;
  reg wr_en;
  reg [4:0] wr_reg;
  reg [15:0] wr_data;

  // Strap decoding: 111 advertises everything, else low bits 11 give 100FD, 01 give 10FD and 10, 00 give 10, 10 give none
  wire strap_all;
  wire adv_rst_100fd;
  wire adv_rst_10fd;
  wire adv_rst_10;
  assign strap_all = (mode_s == 3'b111);
  assign adv_rst_100fd = strap_all | (mode_s[1:0] == 2'b11);
  assign adv_rst_10fd = strap_all | (mode_s[1:0] == 2'b01);
  assign adv_rst_10 = strap_all | ~mode_s[1];

  reg [15:0] rd_data;
  always @*
  begin
    case (addr_sh[4:0])
      `PIAR_OFS_ID_HIGH: rd_data = id_high;
      `PIAR_OFS_ID_LOW: rd_data = id_low;
      `PIAR_OFS_ADV: rd_data = o_adv_word & `PIAR_ADV_WMASK;
      `PIAR_OFS_PARTNER: rd_data = partner & `PIAR_LP_MASK;
      default: rd_data = 16'h0000;
    endcase
  end

  wire addr_hit;
  assign addr_hit = (addr_sh[9:5] == phy_addr_s);

  // Serial frame engine, one step per management clock rising edge
  always @(posedge i_ref_clk)
  begin
    mdc_d <= mdc_s;
    if (i_sys_rst)
    begin
      state <= ST_IDLE;
      pre_cnt <= 6'h00;
      bit_cnt <= 5'h00;
      opcode <= 2'b00;
      addr_sh <= 10'h000;
      data_sh <= 16'h0000;
      wr_en <= 1'b0;
      wr_reg <= 5'h00;
      wr_data <= 16'h0000;
      o_mdio <= 1'b1;
      o_mdio_oe_n <= 1'b1;
    end
    else
    begin
      wr_en <= 1'b0;
      if (mdc_rise)
      begin
        case (state)
          ST_IDLE:
          begin
            if (mdio_s)
            begin
              if (pre_cnt != `PIAR_PREAMBLE_LEN)
              begin
                pre_cnt <= pre_cnt + 6'h01;
              end
            end
            else
            begin
              if (pre_cnt == `PIAR_PREAMBLE_LEN)
              begin
                state <= ST_START;
              end
              pre_cnt <= 6'h00;
            end
          end
          ST_START:
          begin
            bit_cnt <= 5'h00;
            state <= mdio_s ? ST_OPCODE : ST_IDLE;
          end
          ST_OPCODE:
          begin
            opcode <= {opcode[0], mdio_s};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'h01)
            begin
              bit_cnt <= 5'h00;
              state <= ST_ADDR;
            end
          end
          ST_ADDR:
          begin
            addr_sh <= {addr_sh[8:0], mdio_s};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'h09)
            begin
              bit_cnt <= 5'h00;
              if ((addr_sh[8:4] == phy_addr_s) &&
                  ((opcode == `PIAR_OP_READ) || (opcode == `PIAR_OP_WRITE)))
              begin
                state <= ST_TA;
              end
              else
              begin
                state <= ST_IDLE;
              end
            end
          end
          ST_TA:
          begin
            bit_cnt <= bit_cnt + 5'h01;
            if (opcode == `PIAR_OP_READ)
            begin
              if (bit_cnt == 5'h00)
              begin
                o_mdio <= 1'b0;
                o_mdio_oe_n <= 1'b0;
              end
              else
              begin
                o_mdio <= rd_data[15];
                data_sh <= {rd_data[14:0], 1'b0};
                bit_cnt <= 5'h00;
                state <= ST_RDATA;
              end
            end
            else if (bit_cnt == 5'h01)
            begin
              bit_cnt <= 5'h00;
              state <= ST_WDATA;
            end
          end
          ST_RDATA:
          begin
            if (bit_cnt == 5'h0F)
            begin
              o_mdio <= 1'b1;
              o_mdio_oe_n <= 1'b1;
              state <= ST_IDLE;
            end
            else
            begin
              o_mdio <= data_sh[15];
              data_sh <= {data_sh[14:0], 1'b0};
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
          ST_WDATA:
          begin
            data_sh <= {data_sh[14:0], mdio_s};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'h0F)
            begin
              wr_en <= addr_hit;
              wr_reg <= addr_sh[4:0];
              wr_data <= {data_sh[14:0], mdio_s};
              state <= ST_IDLE;
            end
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Identifier registers, writable as the map allows
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      id_high <= OUI_HIGH_RST;
      id_low[`PIAR_IDL_OUI_MSB:`PIAR_IDL_OUI_LSB] <= OUI_LOW_RST;
      id_low[`PIAR_IDL_MODEL_MSB:`PIAR_IDL_MODEL_LSB] <= MODEL_RST;
      id_low[`PIAR_IDL_REV_MSB:`PIAR_IDL_REV_LSB] <= rev_s;
    end
    else if (wr_en && (wr_reg == `PIAR_OFS_ID_HIGH))
    begin
      id_high <= wr_data;
    end
    else if (wr_en && (wr_reg == `PIAR_OFS_ID_LOW))
    begin
      id_low <= wr_data;
    end
  end

  // Advertisement register
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_adv_word <= `PIAR_ADV_RST_FIXED;
      o_adv_word[`PIAR_BIT_PAUSE_ASYM:`PIAR_BIT_PAUSE_SYM] <= `PIAR_PAUSE_NONE;
      o_adv_word[`PIAR_BIT_RFAULT] <= 1'b0;
      o_adv_word[`PIAR_BIT_100FD] <= adv_rst_100fd;
      o_adv_word[`PIAR_BIT_10FD] <= adv_rst_10fd;
      o_adv_word[`PIAR_BIT_10] <= adv_rst_10;
      o_adv_word[`PIAR_SEL_MSB:`PIAR_SEL_LSB] <= `PIAR_SEL_IEEE;
    end
    else if (wr_en && (wr_reg == `PIAR_OFS_ADV))
    begin
      // Reserved positions dropped so they never reach the link
      o_adv_word <= wr_data & `PIAR_ADV_WMASK;
    end
  end

  // Partner ability, filled only by received code words
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      partner <= 16'h0000;
      partner[`PIAR_SEL_MSB:`PIAR_SEL_LSB] <= `PIAR_SEL_IEEE;
    end
    else if (i_lcw_valid)
    begin
      // A new word beats a same-cycle clear
      partner <= i_lcw & `PIAR_LP_MASK;
      partner[`PIAR_BIT_ACK] <= 1'b1;
    end
    else if (i_lcw_clear)
    begin
      partner[`PIAR_BIT_ACK] <= 1'b0;
    end
  end

  // Resolution of the negotiated link
  wire an_done;
  wire [15:0] common;
  assign an_done = i_an_enable & i_an_complete;
  assign common = o_adv_word & partner;

  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_speed100 <= 1'b0;
      o_full_duplex <= 1'b0;
      o_pause_sym <= 1'b0;
      o_pause_asym <= 1'b0;
    end
    else
    begin
      if (i_an_enable)
      begin
        // Highest common ability wins
        o_speed100 <= common[`PIAR_BIT_100FD] | common[`PIAR_BIT_100];
        o_full_duplex <= common[`PIAR_BIT_100FD] |
          (~common[`PIAR_BIT_100] & common[`PIAR_BIT_10FD]);
      end
      else
      begin
        o_speed100 <= i_manual_speed100;
        o_full_duplex <= i_manual_full_duplex;
      end
      // Symmetric preferred; never both at once
      o_pause_sym <= an_done & o_adv_word[`PIAR_BIT_PAUSE_SYM] & partner[`PIAR_BIT_LP_PAUSE];
      o_pause_asym <= an_done & o_adv_word[`PIAR_BIT_PAUSE_ASYM] &
        ~(o_adv_word[`PIAR_BIT_PAUSE_SYM] & partner[`PIAR_BIT_LP_PAUSE]);
    end
  end

endmodule

// ==== piar_regs_asserts.sv ====
`timescale 1ns/1ps
module piar_regs_asserts (
  // Clock, reset, straps
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire [2:0] i_mode_strap,
  // Resolution inputs
  input wire i_an_enable,
  input wire i_an_complete,
  input wire i_manual_speed100,
  input wire i_manual_full_duplex,
  // Watched outputs
  input wire o_mdio,
  input wire o_mdio_oe_n,
  input wire [15:0] o_adv_word,
  input wire o_speed100,
  input wire o_full_duplex,
  input wire o_pause_sym,
  input wire o_pause_asym
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  wire [2:0] m = i_mode_strap;
  a_pause_excl: assert property (!(o_pause_sym && o_pause_asym))
    else $error("both pause kinds resolved");
  a_sym_cause: assert property (o_pause_sym |-> $past(i_an_complete) && $past(o_adv_word[10]))
    else $error("symmetric pause without cause");
  a_asym_cause: assert property (o_pause_asym |-> $past(i_an_complete) && $past(o_adv_word[11]))
    else $error("asymmetric pause without cause");
  a_adv_reset: assert property ($fell(i_sys_rst) |-> (o_adv_word & 16'h3E9F) == 16'h0081)
    else $error("advertisement reset value wrong");
  a_strap_load: assert property ($fell(i_sys_rst) |-> o_adv_word[8] == (&m[1:0])
    && o_adv_word[6] == (&m || m[1:0] == 2'h1) && o_adv_word[5] == (&m || !m[1]))
    else $error("strap abilities not loaded");
  a_adv_reserved: assert property ((o_adv_word & 16'hD200) == 16'h0000)
    else $error("reserved advertisement bit set");
  a_manual_path: assert property (!i_an_enable && !i_sys_rst |=> o_speed100 == $past(i_manual_speed100)
    && o_full_duplex == $past(i_manual_full_duplex))
    else $error("manual selection not followed");
  a_turn_drive: assert property ($fell(o_mdio_oe_n) |-> !o_mdio ##0 !o_mdio_oe_n [*8])
    else $error("turnaround drive wrong");
  cover property (o_pause_sym);
  cover property (o_pause_asym);
  cover property ($fell(o_mdio_oe_n));
endmodule

bind piar_regs piar_regs_asserts u_chk (.*);

// ==== piar_smi_host.sv ====
`timescale 1ns/1ps
module piar_smi_host (
  // Clock
  input wire i_ref_clk,
  // Resolved management line
  input wire i_mdio,
  // Driven management pins
  output logic o_mdc,
  output logic o_mdio
);
  // Half period well above the two-clock sync delay
  localparam int HALF = 6;
  initial
  begin
    o_mdc = 1'h0;
    o_mdio = 1'h1;
  end
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] f;
    logic b;
    f = {2'h1, op, pa, ra, 2'h2, wd};
    rd = 16'h0000;
    for (int k = 0; k < 65; k++)
    begin
      b = (k < 32 || k > 63) ? 1'h1 : f[63 - k];
      // Released line sits at the pull-up level
      if (op == 2'h2 && k >= 46)
        b = 1'h1;
      o_mdio <= b;
      o_mdc <= 1'h0;
      repeat (HALF) @(posedge i_ref_clk);
      if (k >= 48 && k < 64)
        rd = {rd[14:0], i_mdio};
      o_mdc <= 1'h1;
      repeat (HALF) @(posedge i_ref_clk);
    end
    o_mdc <= 1'h0;
    @(posedge i_ref_clk);
  endtask
endmodule

// ==== phy_id_autoneg_ability_regs_tb.sv ====
`timescale 1ns/1ps
`include "piar_map.vh"
module phy_id_autoneg_ability_regs_tb;
  logic i_ref_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic i_mdc, i_mdio;
  logic i_lcw_valid = 1'h0, i_lcw_clear = 1'h0, i_an_complete = 1'h0, i_an_enable = 1'h0;
  logic i_manual_speed100 = 1'h0, i_manual_full_duplex = 1'h0;
  logic [4:0] i_phy_addr = 5'h00;
  logic [2:0] i_mode_strap = 3'h0;
  logic [3:0] i_silicon_rev = 4'h0;
  logic [15:0] i_lcw = 16'h0000, w, lp, rd, v;
  wire o_mdio, o_mdio_oe_n, o_speed100, o_full_duplex, o_pause_sym, o_pause_asym;
  wire [15:0] o_adv_word;
  wire mdio_wire = o_mdio_oe_n ? i_mdio : o_mdio;
  int err_total = 0;
  int compares = 0;

  always #25 i_ref_clk = ~i_ref_clk;
  piar_regs u_piar_regs (.*);
  piar_smi_host u_piar_smi_host (.i_ref_clk(i_ref_clk), .i_mdio(mdio_wire), .o_mdc(i_mdc), .o_mdio(i_mdio));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    u_piar_smi_host.xfer(2'h1, i_phy_addr, a, d, v);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    u_piar_smi_host.xfer(2'h2, i_phy_addr, a, 16'h0000, rd);
    chk(rd, e);
  endtask
  task automatic lcw_put(input logic clr, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_lcw <= d;
    i_lcw_valid <= !clr;
    i_lcw_clear <= clr;
    @(posedge i_ref_clk);
    i_lcw_valid <= 1'h0;
    i_lcw_clear <= 1'h0;
  endtask
  function automatic logic [15:0] adv_rst(input logic [2:0] m);
    adv_rst = 16'h0081 | {7'h0, &m[1:0], 1'h0, &m | m[1:0] == 2'h1, &m | !m[1], 5'h0};
  endfunction
  function automatic logic [1:0] best(input logic [15:0] c);
    best = c[8] ? 2'h3 : c[7] ? 2'h2 : c[6] ? 2'h1 : 2'h0;
  endfunction

  // Bound is about three times the expected frame traffic
  initial
  begin
    repeat (80000) @(posedge i_ref_clk);
    err_total++;
    test_done;
  end

  initial
  begin
    void'($urandom(94898));
    i_mode_strap <= 3'($urandom);
    i_silicon_rev <= 4'($urandom);
    i_phy_addr <= 5'($urandom);
    repeat (12) @(posedge i_ref_clk);
    i_sys_rst <= 1'h0;
    repeat (2) @(posedge i_ref_clk);
    rd_chk(`PIAR_OFS_ID_HIGH, 16'h1234);
    rd_chk(`PIAR_OFS_ID_LOW, {6'h2A, 6'h15, i_silicon_rev});
    rd_chk(`PIAR_OFS_ADV, adv_rst(i_mode_strap));
    rd_chk(`PIAR_OFS_PARTNER, 16'h0001);
    $display("test 1 reset values done");
    for (int p = 0; p < 4; p++)
    begin
      w = 16'($urandom);
      w[11:10] = p[1:0];
      wr(`PIAR_OFS_ADV, w);
      rd_chk(`PIAR_OFS_ADV, w & 16'h2DFF);
    end
    wr(5'h09, 16'hFFFF);
    rd_chk(5'h09, 16'h0000);
    w = 16'($urandom);
    wr(`PIAR_OFS_ID_HIGH, w);
    rd_chk(`PIAR_OFS_ID_HIGH, w);
    $display("test 2 writes done");
    w = 16'($urandom);
    lcw_put(1'h0, w);
    rd_chk(`PIAR_OFS_PARTNER, (w & 16'hE7FF) | 16'h4000);
    wr(`PIAR_OFS_PARTNER, ~w);
    rd_chk(`PIAR_OFS_PARTNER, (w & 16'hE7FF) | 16'h4000);
    lcw_put(1'h1, w);
    rd_chk(`PIAR_OFS_PARTNER, w & 16'hA7FF);
    $display("test 3 partner done");
    for (int n = 0; n < 6; n++)
    begin
      w = 16'($urandom) | 16'h0020;
      lp = 16'($urandom) | 16'h0020;
      // First two rounds force the both-pause corner
      if (n < 2)
      begin
        w[11:10] = 2'h3;
        lp[10] = !n[0];
      end
      wr(`PIAR_OFS_ADV, w);
      lcw_put(1'h0, lp);
      w = w & 16'h2DFF;
      chk(o_adv_word, w);
      i_an_enable <= 1'h1;
      i_an_complete <= 1'h1;
      i_manual_speed100 <= 1'($urandom);
      i_manual_full_duplex <= 1'($urandom);
      repeat (3) @(posedge i_ref_clk);
      #1;
      chk({o_speed100, o_full_duplex}, best(w & lp));
      chk({o_pause_sym, o_pause_asym}, {w[10] & lp[10], w[11] & !(w[10] & lp[10])});
      @(posedge i_ref_clk);
      i_an_enable <= 1'h0;
      i_an_complete <= 1'h0;
      repeat (3) @(posedge i_ref_clk);
      #1;
      chk({o_speed100, o_full_duplex}, {i_manual_speed100, i_manual_full_duplex});
      @(posedge i_ref_clk);
    end
    $display("test 4 resolution done");
    // Mid-run reset with corner straps; earlier ID writes must be undone
    for (int r = 0; r < 2; r++)
    begin
      i_sys_rst <= 1'h1;
      i_mode_strap <= r[0] ? 3'h7 : 3'h2;
      i_silicon_rev <= 4'($urandom);
      repeat (12) @(posedge i_ref_clk);
      i_sys_rst <= 1'h0;
      repeat (2) @(posedge i_ref_clk);
      chk(o_adv_word, adv_rst(i_mode_strap));
      rd_chk(`PIAR_OFS_ID_HIGH, 16'h1234);
      rd_chk(`PIAR_OFS_ID_LOW, {6'h2A, 6'h15, i_silicon_rev});
      rd_chk(`PIAR_OFS_ADV, adv_rst(i_mode_strap));
      rd_chk(`PIAR_OFS_PARTNER, 16'h0001);
    end
    $display("test 5 mid-run reset done");
    test_done;
  end
endmodule
